/* include/rsc_cfg.svh */
// Constants of the radio state control block: offsets, fields, codes and timing
// ****************************************************************************
// Overview of operation
// - Status register bits 4:0 show the current radio state, read only.
// - Basic state codes: 00 power-on, 01/02 busy, 06 listen, 08 off, 09 synth, 0F sleep.
// - Extended codes 11, 12, 16, 19 appear only in the extended modes.
// - Code 1F is shown while a state transition is still running.
// - In sleep the registers cannot be reached; host must not read sleep code.
// - Status bit 7 flags Channel_assess_done, bit 6 its result, bit 5 reserved zero.
// - A write of 06, 08, 09, 16 or 19 in another stable state starts a transition toward it; power-on takes only 08.
// - Command 00 does nothing, 03 forces off, 04 forces synth, 02 launches transmit.
// - Commands 06 listen, 08 off, 09 synth; 16 and 19 enter extended modes.
// - The command field holds zero after reset.
// - Transmission begins one symbol period after the launch command in synth; in retry transmit, one symbol after a clear CCA.
// - Force-synth is ignored in power-on, sleep and the wake-up transition out of sleep.
// - A rising trigger pin edge starts some transitions instead of a command.
// - Command register bits 7:5 hold the read-only transaction result.
// - Commands arriving while busy in auto-ack receive wait until it finishes.
// - Force-off and force-synth abort auto-ack receive immediately.
// - Auto-ack receive always checks the FCS of each incoming frame.
// - Retry transmit accepts an ACK in time, FCS good, sequence matching; pending bit picks result.
// - Auto-ack receive raises address-match, reports only filtered good frames, acks on request.
// - Retry transmit does CSMA-CA with backoff, waits ACK, retries, reports.
// - Retry transmit transaction starts on trigger edge or launch command.
// - Off to an extended mode passes through synth; synth lock event is raised.
// ****************************************************************************
`ifndef RSC_CFG_SVH
`define RSC_CFG_SVH

// ****************************************************************************
// Register map and fields
// ****************************************************************************
`define RSC_OFS_STATUS 6'h01
`define RSC_OFS_STATE_CMD 6'h02
`define RSC_CODE_MSB 4
`define RSC_CHANNEL_ASSESS_DONE_BIT 7
`define RSC_CCA_IDLE_BIT 6
`define RSC_TRAC_LSB 5
`define RSC_CMD_RESET 5'h00
`define RSC_TRAC_RESET 3'h0
`define RSC_LFSR_SEED 8'hA5

// ****************************************************************************
// Command codes
// ****************************************************************************
`define RSC_CMD_NOP 5'h00
`define RSC_CMD_TX_START 5'h02
`define RSC_CMD_FORCE_OFF 5'h03
`define RSC_CMD_FORCE_SYNTH 5'h04
`define RSC_CMD_RX_LISTEN 5'h06
`define RSC_CMD_OFF 5'h08
`define RSC_CMD_SYNTH 5'h09
`define RSC_CMD_AACK 5'h16
`define RSC_CMD_ARET 5'h19

// ****************************************************************************
// State codes
// ****************************************************************************
`define RSC_ST_P_ON 5'h00
`define RSC_ST_BUSY_RX 5'h01
`define RSC_ST_BUSY_TX 5'h02
`define RSC_ST_RX_LISTEN 5'h06
`define RSC_ST_OFF 5'h08
`define RSC_ST_SYNTH 5'h09
`define RSC_ST_SLEEP 5'h0F
`define RSC_ST_AACK_BUSY 5'h11
`define RSC_ST_ARET_BUSY 5'h12
`define RSC_ST_AACK_LISTEN 5'h16
`define RSC_ST_ARET_READY 5'h19
`define RSC_ST_IN_TRANSITION 5'h1F

// ****************************************************************************
// Transaction result codes
// ****************************************************************************
`define RSC_TRAC_SUCCESS 3'h0
`define RSC_TRAC_SUCCESS_PENDING 3'h1
`define RSC_TRAC_CHANNEL_FAIL 3'h3
`define RSC_TRAC_NO_ACK 3'h5

// ****************************************************************************
// Timing
// ****************************************************************************
`define RSC_CLK_PERIOD_NS 100
`define RSC_NS_TO_CYC(ns) (((ns) + `RSC_CLK_PERIOD_NS - 1) / `RSC_CLK_PERIOD_NS)
`define RSC_T_FAST_NS 1000
`define RSC_T_SETTLE_NS 80000
`define RSC_T_SYMBOL_NS 16000
`define RSC_T_PON_NS 360000
`define RSC_T_WAKE_NS 1000000
`define RSC_T_ACK_WAIT_NS 864000
`define RSC_T_FAST_CYC `RSC_NS_TO_CYC(`RSC_T_FAST_NS)
`define RSC_T_SETTLE_CYC `RSC_NS_TO_CYC(`RSC_T_SETTLE_NS)
`define RSC_T_SYMBOL_CYC `RSC_NS_TO_CYC(`RSC_T_SYMBOL_NS)
`define RSC_T_PON_CYC `RSC_NS_TO_CYC(`RSC_T_PON_NS)
`define RSC_T_WAKE_CYC `RSC_NS_TO_CYC(`RSC_T_WAKE_NS)
`define RSC_T_ACK_WAIT_CYC `RSC_NS_TO_CYC(`RSC_T_ACK_WAIT_NS)
`define RSC_TMR_W 14

`endif

/* include/rsc_pkg.sv */
// Types of the radio state control block
package rsc_pkg;

  typedef enum logic [4:0] {
    ST_P_ON, ST_SLEEP, ST_WAKE, ST_OFF, ST_SYNTH, ST_RX_LISTEN, ST_RX_BUSY, ST_TX_BUSY, ST_TRANS,
    ST_AACK_LISTEN, ST_AACK_BUSY, ST_AACK_ACKTX,
    ST_ARET_READY, ST_ARET_BACKOFF, ST_ARET_CCA, ST_ARET_TX, ST_ARET_ACKWAIT
  } rsc_state_t;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [5:0] addr;
    logic [7:0] wdata;
  } rsc_reg_req_t;

  typedef struct packed {
    logic rx_start;
    logic rx_end;
    logic fcs_ok;
    logic addr_match;
    logic ack_req;
  } rsc_rx_evt_t;

  typedef struct packed {
    logic ack_rx;
    logic fcs_ok;
    logic seq_ok;
    logic pending;
  } rsc_ack_evt_t;

  typedef struct packed {
    logic tx_start;
    logic ack_tx_start;
    logic cca_req;
    logic frame_rcvd;
    logic addr_match_event;
    logic synth_lock_event;
    logic aret_done;
  } rsc_radio_ctl_t;

endpackage : rsc_pkg

/* logic/rsc_rise_detect.sv */
// Rising edge detector for the trigger pin
`timescale 1ns/1ps
`default_nettype none
module rsc_rise_detect (
  input wire logic clk_sys_i,
  input wire logic sys_rst_i,
  input wire logic level_i,
  output logic rise_o
);
  typedef struct packed {
    logic prev;
  } rsc_edge_t;

  rsc_edge_t edge_reg;
  rsc_edge_t edge_next;

  always_comb
  begin
    edge_next.prev = level_i;
  end

  // Reset to high so a pin held high through reset is not seen as an edge
  always_ff @(posedge clk_sys_i)
  begin
    if (sys_rst_i)
      edge_reg <= '1;
    else
      edge_reg <= edge_next;
  end

  assign rise_o = level_i && !edge_reg.prev;

endmodule : rsc_rise_detect
`default_nettype wire

/* logic/rsc_state_ctrl.sv */
// Radio state controller: command decode, state tracking, status readback, MAC modes
`timescale 1ns/1ps
`default_nettype none
`include "rsc_cfg.svh"
module rsc_state_ctrl #(
  parameter int unsigned T_FAST_CYC = `RSC_T_FAST_CYC,
  parameter int unsigned T_SETTLE_CYC = `RSC_T_SETTLE_CYC,
  parameter int unsigned T_SYMBOL_CYC = `RSC_T_SYMBOL_CYC,
  parameter int unsigned T_PON_CYC = `RSC_T_PON_CYC,
  parameter int unsigned T_WAKE_CYC = `RSC_T_WAKE_CYC,
  parameter int unsigned T_ACK_WAIT_CYC = `RSC_T_ACK_WAIT_CYC,
  parameter logic [3:0] MAX_CSMA_RETRIES = 4'h4,
  parameter logic [3:0] MAX_FRAME_RETRIES = 4'h3
) (
  input wire logic clk_sys_i,
  input wire logic sys_rst_i,
  input wire rsc_pkg::rsc_reg_req_t reg_req_i,
  output logic [7:0] reg_rdata_o,
  input wire logic sleep_or_tx_trigger_i,
  input wire rsc_pkg::rsc_rx_evt_t rx_evt_i,
  input wire logic tx_done_i,
  input wire logic tx_ack_req_i,
  input wire rsc_pkg::rsc_ack_evt_t ack_evt_i,
  input wire logic channel_assess_done_i,
  input wire logic cca_busy_i,
  output rsc_pkg::rsc_radio_ctl_t radio_ctl_o,
  output logic [4:0] radio_state_code_o
);
  import rsc_pkg::*;

  localparam int unsigned TW = `RSC_TMR_W;

  typedef struct packed {
    rsc_state_t st;
    rsc_state_t tgt;
    logic from_off;
    logic [4:0] cmd;
    logic [4:0] pend_cmd;
    logic pend_vld;
    logic [2:0] trac;
    logic channel_assess_done;
    logic cca_idle;
    logic amatch;
    logic launched;
    logic [3:0] csma_cnt;
    logic [3:0] frame_cnt;
    logic [7:0] lfsr;
    logic [7:0] rdata;
    rsc_radio_ctl_t ctl;
  } rsc_core_t;

  rsc_core_t s_reg;
  rsc_core_t s_next;

  logic trig_rise;
  logic tmr_exp;
  logic tmr_load;
  logic [TW-1:0] tmr_val;

  // ****************************************************************************
  // Helpers
  // ****************************************************************************
  rsc_rise_detect u_trig (
    .clk_sys_i(clk_sys_i),
    .sys_rst_i(sys_rst_i),
    .level_i(sleep_or_tx_trigger_i),
    .rise_o(trig_rise)
  );

  rsc_timer #(.W(TW)) u_tmr (
    .clk_sys_i(clk_sys_i),
    .sys_rst_i(sys_rst_i),
    .load_i(tmr_load),
    .value_i(tmr_val),
    .expire_o(tmr_exp)
  );

  function automatic logic [4:0] state_code(input rsc_state_t st);
    logic [4:0] c;
    c = `RSC_ST_ARET_BUSY;
    unique case (st)
      ST_P_ON: c = `RSC_ST_P_ON;
      ST_SLEEP: c = `RSC_ST_SLEEP;
      ST_OFF: c = `RSC_ST_OFF;
      ST_SYNTH: c = `RSC_ST_SYNTH;
      ST_RX_LISTEN: c = `RSC_ST_RX_LISTEN;
      ST_RX_BUSY: c = `RSC_ST_BUSY_RX;
      ST_TX_BUSY: c = `RSC_ST_BUSY_TX;
      ST_WAKE, ST_TRANS: c = `RSC_ST_IN_TRANSITION;
      ST_AACK_LISTEN: c = `RSC_ST_AACK_LISTEN;
      ST_AACK_BUSY, ST_AACK_ACKTX: c = `RSC_ST_AACK_BUSY;
      ST_ARET_READY: c = `RSC_ST_ARET_READY;
      ST_ARET_BACKOFF, ST_ARET_CCA, ST_ARET_TX, ST_ARET_ACKWAIT: c = `RSC_ST_ARET_BUSY;
    endcase
    return c;
  endfunction : state_code

  // ****************************************************************************
  // Next state
  // ****************************************************************************
  logic wr_cmd;
  logic busy;
  logic stable;
  logic use_cmd;
  logic [4:0] cur;
  logic go;
  rsc_state_t go_tgt;
  logic [TW-1:0] go_cyc;

  always_comb
  begin
    s_next = s_reg;
    s_next.ctl = '0;
    s_next.lfsr = {s_reg.lfsr[6:0], s_reg.lfsr[7] ^ s_reg.lfsr[5] ^ s_reg.lfsr[4] ^ s_reg.lfsr[3]};
    tmr_load = 1'b0;
    tmr_val = '0;
    go = 1'b0;
    go_tgt = s_reg.st;
    go_cyc = '0;
    use_cmd = 1'b0;
    cur = `RSC_CMD_NOP;
    // Registers are unreachable in sleep
    wr_cmd = reg_req_i.wr && (reg_req_i.addr == `RSC_OFS_STATE_CMD) && (s_reg.st != ST_SLEEP);
    busy = s_reg.st inside {ST_RX_BUSY, ST_TX_BUSY, ST_AACK_BUSY, ST_AACK_ACKTX,
                            ST_ARET_BACKOFF, ST_ARET_CCA, ST_ARET_TX, ST_ARET_ACKWAIT};
    stable = !busy && !(s_reg.st inside {ST_TRANS, ST_WAKE, ST_SLEEP});

    if (wr_cmd)
    begin
      s_next.cmd = reg_req_i.wdata[`RSC_CODE_MSB:0];
    end

    // Per-state events
    unique case (s_reg.st)
      ST_TRANS:
      begin
        if (tmr_exp)
        begin
          s_next.st = s_reg.tgt;
          s_next.ctl.synth_lock_event = s_reg.from_off;
        end
      end
      ST_WAKE:
      begin
        if (tmr_exp)
          s_next.st = ST_OFF;
      end
      ST_RX_LISTEN:
      begin
        if (rx_evt_i.rx_start)
          s_next.st = ST_RX_BUSY;
      end
      ST_RX_BUSY:
      begin
        if (rx_evt_i.rx_end)
        begin
          s_next.st = ST_RX_LISTEN;
          s_next.ctl.frame_rcvd = 1'b1;
        end
      end
      ST_TX_BUSY, ST_ARET_TX:
      begin
        if (tmr_exp && !s_reg.launched)
        begin
          s_next.ctl.tx_start = 1'b1;
          s_next.launched = 1'b1;
        end
        if (tx_done_i && s_reg.launched)
        begin
          if (s_reg.st == ST_TX_BUSY)
            s_next.st = ST_SYNTH;
          else if (tx_ack_req_i)
          begin
            s_next.st = ST_ARET_ACKWAIT;
            tmr_load = 1'b1;
            tmr_val = TW'(T_ACK_WAIT_CYC);
          end
          else
          begin
            s_next.st = ST_ARET_READY;
            s_next.trac = `RSC_TRAC_SUCCESS;
            s_next.ctl.aret_done = 1'b1;
          end
        end
      end
      ST_AACK_LISTEN:
      begin
        if (rx_evt_i.rx_start)
        begin
          s_next.st = ST_AACK_BUSY;
          s_next.amatch = 1'b0;
        end
      end
      ST_AACK_BUSY:
      begin
        if (rx_evt_i.addr_match)
        begin
          s_next.amatch = 1'b1;
          s_next.ctl.addr_match_event = 1'b1;
        end
        if (rx_evt_i.rx_end)
        begin
          s_next.st = ST_AACK_LISTEN;
          // Frames failing the filter or FCS are dropped silently
          if (rx_evt_i.fcs_ok && (s_reg.amatch || rx_evt_i.addr_match))
          begin
            s_next.ctl.frame_rcvd = 1'b1;
            s_next.trac = `RSC_TRAC_SUCCESS;
            if (rx_evt_i.ack_req)
            begin
              s_next.st = ST_AACK_ACKTX;
              s_next.ctl.ack_tx_start = 1'b1;
            end
          end
        end
      end
      ST_AACK_ACKTX:
      begin
        if (tx_done_i)
          s_next.st = ST_AACK_LISTEN;
      end
      ST_ARET_BACKOFF:
      begin
        if (tmr_exp)
        begin
          s_next.st = ST_ARET_CCA;
          s_next.ctl.cca_req = 1'b1;
          s_next.channel_assess_done = 1'b0;
        end
      end
      ST_ARET_CCA:
      begin
        if (channel_assess_done_i && !cca_busy_i)
        begin
          s_next.st = ST_ARET_TX;
          s_next.launched = 1'b0;
          tmr_load = 1'b1;
          tmr_val = TW'(T_SYMBOL_CYC);
        end
        else if (channel_assess_done_i && (s_reg.csma_cnt == MAX_CSMA_RETRIES))
        begin
          s_next.st = ST_ARET_READY;
          s_next.trac = `RSC_TRAC_CHANNEL_FAIL;
          s_next.ctl.aret_done = 1'b1;
        end
        else if (channel_assess_done_i)
        begin
          s_next.st = ST_ARET_BACKOFF;
          s_next.csma_cnt = s_reg.csma_cnt + 4'h1;
          tmr_load = 1'b1;
          tmr_val = {3'h0, s_reg.lfsr[2:0], 8'hFF};
        end
      end
      ST_ARET_ACKWAIT:
      begin
        if (ack_evt_i.ack_rx && ack_evt_i.fcs_ok && ack_evt_i.seq_ok)
        begin
          s_next.st = ST_ARET_READY;
          s_next.trac = ack_evt_i.pending ? `RSC_TRAC_SUCCESS_PENDING : `RSC_TRAC_SUCCESS;
          s_next.ctl.aret_done = 1'b1;
        end
        else if (tmr_exp && (s_reg.frame_cnt == MAX_FRAME_RETRIES))
        begin
          s_next.st = ST_ARET_READY;
          s_next.trac = `RSC_TRAC_NO_ACK;
          s_next.ctl.aret_done = 1'b1;
        end
        else if (tmr_exp)
        begin
          s_next.st = ST_ARET_BACKOFF;
          s_next.frame_cnt = s_reg.frame_cnt + 4'h1;
          s_next.csma_cnt = '0;
          tmr_load = 1'b1;
          tmr_val = {3'h0, s_reg.lfsr[2:0], 8'hFF};
        end
      end
      default:
      begin
      end
    endcase

    // CCA result, a new result wins over the clear above
    if (channel_assess_done_i)
    begin
      s_next.channel_assess_done = 1'b1;
      s_next.cca_idle = !cca_busy_i;
    end

    // Command selection: forced, deferred or applied
    if (wr_cmd && (reg_req_i.wdata[4:0] inside {`RSC_CMD_FORCE_OFF, `RSC_CMD_FORCE_SYNTH}))
    begin
      if (!(s_reg.st inside {ST_P_ON, ST_SLEEP, ST_WAKE}))
      begin
        go = 1'b1;
        go_tgt = (reg_req_i.wdata[4:0] == `RSC_CMD_FORCE_OFF) ? ST_OFF : ST_SYNTH;
        go_cyc = TW'(T_FAST_CYC);
        s_next.pend_vld = 1'b0;
      end
    end
    else if (wr_cmd && busy && (reg_req_i.wdata[4:0] != `RSC_CMD_NOP))
    begin
      s_next.pend_cmd = reg_req_i.wdata[4:0];
      s_next.pend_vld = 1'b1;
    end
    else if (wr_cmd && stable)
    begin
      use_cmd = 1'b1;
      cur = reg_req_i.wdata[4:0];
    end
    else if (s_reg.pend_vld && stable)
    begin
      use_cmd = 1'b1;
      cur = s_reg.pend_cmd;
      s_next.pend_vld = 1'b0;
    end
    // A write during a transition is dropped, except force-off or force-synth outside the wake-up: the host must wait for a stable code

    if (use_cmd)
    begin
      unique case (cur)
        `RSC_CMD_OFF:
        begin
          go = (s_reg.st != ST_OFF);
          go_tgt = ST_OFF;
          go_cyc = (s_reg.st == ST_P_ON) ? TW'(T_PON_CYC) : TW'(T_FAST_CYC);
        end
        `RSC_CMD_SYNTH, `RSC_CMD_RX_LISTEN:
        begin
          go_tgt = (cur == `RSC_CMD_SYNTH) ? ST_SYNTH : ST_RX_LISTEN;
          go = (s_reg.st != ST_P_ON) && (s_reg.st != go_tgt);
          go_cyc = (s_reg.st == ST_OFF) ? TW'(T_SETTLE_CYC) : TW'(T_FAST_CYC);
        end
        `RSC_CMD_AACK, `RSC_CMD_ARET:
        begin
          go_tgt = (cur == `RSC_CMD_AACK) ? ST_AACK_LISTEN : ST_ARET_READY;
          go = (s_reg.st != ST_P_ON) && (s_reg.st != go_tgt);
          go_cyc = TW'(T_FAST_CYC);
          if (s_reg.st == ST_OFF)
          begin
            go_tgt = ST_SYNTH;
            go_cyc = TW'(T_SETTLE_CYC);
            s_next.pend_cmd = cur;
            s_next.pend_vld = 1'b1;
          end
        end
        `RSC_CMD_TX_START:
        begin
          if (s_reg.st == ST_SYNTH)
          begin
            s_next.st = ST_TX_BUSY;
            s_next.launched = 1'b0;
            tmr_load = 1'b1;
            tmr_val = TW'(T_SYMBOL_CYC);
          end
          else if (s_reg.st == ST_ARET_READY)
          begin
            s_next.st = ST_ARET_BACKOFF;
            s_next.csma_cnt = '0;
            s_next.frame_cnt = '0;
            tmr_load = 1'b1;
            tmr_val = {3'h0, s_reg.lfsr[2:0], 8'hFF};
          end
        end
        default:
        begin
          // No operation and reserved values leave the state alone
        end
      endcase
    end
    else if (trig_rise)
    begin
      if (s_reg.st == ST_OFF)
        s_next.st = ST_SLEEP;
      else if (s_reg.st == ST_SLEEP)
      begin
        s_next.st = ST_WAKE;
        tmr_load = 1'b1;
        tmr_val = TW'(T_WAKE_CYC);
      end
      else if (s_reg.st == ST_SYNTH)
      begin
        s_next.st = ST_TX_BUSY;
        s_next.launched = 1'b0;
        tmr_load = 1'b1;
        tmr_val = TW'(T_SYMBOL_CYC);
      end
      else if (s_reg.st == ST_ARET_READY)
      begin
        s_next.st = ST_ARET_BACKOFF;
        s_next.csma_cnt = '0;
        s_next.frame_cnt = '0;
        tmr_load = 1'b1;
        tmr_val = {3'h0, s_reg.lfsr[2:0], 8'hFF};
      end
    end

    if (go)
    begin
      s_next.st = ST_TRANS;
      s_next.tgt = go_tgt;
      s_next.from_off = (s_reg.st == ST_OFF);
      tmr_load = 1'b1;
      tmr_val = go_cyc;
    end

    // Register readback
    if (reg_req_i.rd)
    begin
      s_next.rdata = 8'h00;
      if (s_reg.st != ST_SLEEP)
      begin
        if (reg_req_i.addr == `RSC_OFS_STATUS)
          s_next.rdata = {s_reg.channel_assess_done, s_reg.cca_idle, 1'b0, state_code(s_reg.st)};
        else if (reg_req_i.addr == `RSC_OFS_STATE_CMD)
          s_next.rdata = {s_reg.trac, s_reg.cmd};
      end
    end
  end

  // ****************************************************************************
  // State register
  // ****************************************************************************
  always_ff @(posedge clk_sys_i)
  begin
    if (sys_rst_i)
    begin
      s_reg <= '0;
      s_reg.cmd <= `RSC_CMD_RESET;
      s_reg.trac <= `RSC_TRAC_RESET;
      s_reg.lfsr <= `RSC_LFSR_SEED;
    end
    else
    begin
      s_reg <= s_next;
    end
  end

  assign reg_rdata_o = s_reg.rdata;
  assign radio_ctl_o = s_reg.ctl;
  assign radio_state_code_o = state_code(s_reg.st);

endmodule : rsc_state_ctrl
`default_nettype wire

/* logic/rsc_timer.sv */
// Down counter that pulses once a loaded number of cycles has passed
`timescale 1ns/1ps
`default_nettype none
module rsc_timer #(
  parameter int unsigned W = 14
) (
  input wire logic clk_sys_i,
  input wire logic sys_rst_i,
  input wire logic load_i,
  input wire logic [W-1:0] value_i,
  output logic expire_o
);
  typedef struct packed {
    logic [W-1:0] cnt;
  } rsc_tmr_t;

  rsc_tmr_t tmr_reg;
  rsc_tmr_t tmr_next;

  always_comb
  begin
    tmr_next = tmr_reg;
    if (load_i)
    begin
      tmr_next.cnt = value_i;
    end
    else if (tmr_reg.cnt != '0)
    begin
      tmr_next.cnt = tmr_reg.cnt - W'(1);
    end
  end

  always_ff @(posedge clk_sys_i)
  begin
    if (sys_rst_i)
      tmr_reg <= '0;
    else
      tmr_reg <= tmr_next;
  end

  // Taken from the count alone: the caller's load depends on this pulse
  assign expire_o = (tmr_reg.cnt == W'(1));

endmodule : rsc_timer
`default_nettype wire

/* verif/rsc_host_model.sv */
// Host model: register cycles and state polling on the strobe port
`timescale 1ns/1ps
`default_nettype none
module rsc_host_model (
  input wire logic clk_sys_i,
  input wire logic [7:0] rdata_i,
  output var rsc_pkg::rsc_reg_req_t reg_req_o
);
  import rsc_pkg::*;
  initial reg_req_o = '0;
  // ********
  // Bus cycles
  // ********
  // Released address and data are inverted so no stale value looks valid
  task automatic acc(input logic w, input logic [5:0] a, input logic [7:0] wd, output logic [7:0] d);
    @(negedge clk_sys_i);
    reg_req_o = '{wr: w, rd: !w, addr: a, wdata: wd};
    @(negedge clk_sys_i);
    d = rdata_i;
    reg_req_o = '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~wd};
  endtask : acc
  // Want 1F stops after the first read, whatever code comes back
  task automatic poll(input logic [4:0] want, output logic [7:0] d);
    int n;
    n = 0;
    do
    begin
      acc(1'b0, 6'h01, 8'h00, d);
      n++;
    end
    while (n < 400 && d[4:0] != want && !(want == 5'h1F && d[4:0] != 5'h1F));
  endtask : poll
  task automatic cmd(input logic [7:0] v);
    logic [7:0] d;
    poll(5'h1F, d);
    acc(1'b1, 6'h02, v, d);
  endtask : cmd
endmodule : rsc_host_model
`default_nettype wire

/* verif/rsc_state_ctrl_chk.sv */
// Port checks of the radio state controller
`timescale 1ns/1ps
`default_nettype none
module rsc_state_ctrl_chk (
  input wire logic clk_sys_i,
  input wire logic sys_rst_i,
  input wire rsc_pkg::rsc_reg_req_t reg_req_i,
  input wire logic [7:0] reg_rdata_o,
  input wire logic sleep_or_tx_trigger_i,
  input wire rsc_pkg::rsc_rx_evt_t rx_evt_i,
  input wire rsc_pkg::rsc_radio_ctl_t radio_ctl_o,
  input wire logic [4:0] radio_state_code_o
);
  import rsc_pkg::*;
  wire logic [4:0] c = radio_state_code_o;
  wire logic cw = reg_req_i.wr && reg_req_i.addr == 6'h02;
  wire logic [4:0] wc = reg_req_i.wdata[4:0];
  // ********
  // Assertions
  // ********
  default clocking @(posedge clk_sys_i);
  endclocking
  default disable iff (sys_rst_i);
  a_status_code_read: assert property (reg_req_i.rd && reg_req_i.addr == 6'h01 && c != 5'h0F
    |=> reg_rdata_o[5:0] == {1'b0, $past(c)}) else $error("status read wrong");
  a_sleep_read_zero: assert property (reg_req_i.rd && c == 5'h0F |=> reg_rdata_o == 8'h00)
    else $error("sleep read not zero");
  a_legal_code: assert property (c inside {5'h00, 5'h01, 5'h02, 5'h06, 5'h08, 5'h09, 5'h0F, 5'h11,
    5'h12, 5'h16, 5'h19, 5'h1F}) else $error("reserved state code");
  a_cmd_starts_move: assert property (cw && wc inside {5'h06, 5'h09} && c == 5'h08
    |=> c == 5'h1F [*8]) else $error("no transition code");
  a_reserved_no_move: assert property (cw && !(wc inside {5'h02, 5'h03, 5'h04, 5'h06, 5'h08, 5'h09, 5'h16,
    5'h19}) && c inside {5'h00, 5'h08, 5'h09} && !sleep_or_tx_trigger_i |=> $stable(c))
    else $error("reserved command moved state");
  a_synth_force_ignored: assert property (cw && wc == 5'h04 && c inside {5'h00, 5'h0F} |=> $stable(c))
    else $error("force synth accepted");
  a_tx_one_symbol: assert property (cw && wc == 5'h02 && c == 5'h09 |=>
    (c == 5'h02 && !radio_ctl_o.tx_start) [*4] ##[1:20] radio_ctl_o.tx_start) else $error("tx start timing");
  a_trigger_sleep: assert property (c == 5'h08 && $rose(sleep_or_tx_trigger_i) && !cw |-> ##[1:2] c == 5'h0F)
    else $error("trigger did not sleep");
  a_force_abort_aack: assert property (cw && wc == 5'h03 && c inside {5'h11, 5'h16} |=>
    c == 5'h1F ##[1:12] c == 5'h08) else $error("force off not taken");
  a_bad_fcs_dropped: assert property (c == 5'h11 && rx_evt_i.rx_end && !rx_evt_i.fcs_ok |=>
    !radio_ctl_o.frame_rcvd) else $error("bad frame reported");
  c_sleep: cover property (c == 5'h0F);
  c_aack_busy: cover property (c == 5'h11);
  c_tx_start: cover property (radio_ctl_o.tx_start);
endmodule : rsc_state_ctrl_chk
bind rsc_state_ctrl rsc_state_ctrl_chk i_chk (.clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i),
  .reg_req_i(reg_req_i), .reg_rdata_o(reg_rdata_o), .sleep_or_tx_trigger_i(sleep_or_tx_trigger_i),
  .rx_evt_i(rx_evt_i), .radio_ctl_o(radio_ctl_o), .radio_state_code_o(radio_state_code_o));
`default_nettype wire

/* verif/rsc_state_ctrl_tb.sv */
// Self-checking bench of the radio state controller
`timescale 1ns/1ps
`default_nettype none
module rsc_state_ctrl_tb;
  import rsc_pkg::*;
  logic clk_sys_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic trig = 1'b0;
  logic tx_done = 1'b0;
  logic tx_ack_req = 1'b0;
  logic channel_assess_done = 1'b0;
  logic cca_busy = 1'b0;
  rsc_ack_evt_t ack = '0;
  rsc_reg_req_t req;
  rsc_rx_evt_t rx = '0;
  rsc_radio_ctl_t ctl;
  logic [7:0] rdata, d, r;
  logic [4:0] code;
  int err_count = 0;
  int samples_checked = 0;
  int cyc = 0;
  int n_tx = 0;
  int n_rcv = 0;
  int n_ack = 0;
  rsc_state_ctrl #(.T_SETTLE_CYC(20), .T_SYMBOL_CYC(8), .T_PON_CYC(20), .T_WAKE_CYC(50),
    .T_ACK_WAIT_CYC(50)) i_dut (.clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i), .reg_req_i(req),
    .reg_rdata_o(rdata), .sleep_or_tx_trigger_i(trig), .rx_evt_i(rx), .tx_done_i(tx_done), .tx_ack_req_i(tx_ack_req),
    .ack_evt_i(ack), .channel_assess_done_i(channel_assess_done), .cca_busy_i(cca_busy), .radio_ctl_o(ctl), .radio_state_code_o(code));
  rsc_host_model i_host (.clk_sys_i(clk_sys_i), .rdata_i(rdata), .reg_req_o(req));
  initial forever #50 clk_sys_i = ~clk_sys_i;
  always @(posedge clk_sys_i)
  begin
    cyc <= cyc + 1;
    n_tx <= n_tx + int'(ctl.tx_start);
    n_rcv <= n_rcv + int'(ctl.frame_rcvd);
    n_ack <= n_ack + int'(ctl.ack_tx_start);
    if (cyc == 30000)
    begin
      err_count++;
      print_verdict();
    end
  end
  // ********
  // Helpers
  // ********
  function automatic logic [7:0] stat(input logic [4:0] c);
    return {3'h0, c};
  endfunction : stat
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      err_count++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic ev(input rsc_rx_evt_t v, input logic td);
    @(negedge clk_sys_i);
    rx = v;
    tx_done = td;
    @(negedge clk_sys_i);
    rx = '0;
    tx_done = 1'b0;
  endtask : ev
  task automatic pk(input rsc_ack_evt_t a, input logic c);
    @(negedge clk_sys_i);
    ack = a;
    channel_assess_done = c;
    @(negedge clk_sys_i);
    ack = '0;
    channel_assess_done = 1'b0;
  endtask : pk
  task automatic cc(input logic b);
    for (int i = 0; i < 2100 && !ctl.cca_req; i++) @(negedge clk_sys_i);
    cca_busy = b;
    pk('0, 1'b1);
  endtask : cc
  task automatic go(input logic [7:0] v, input logic [4:0] want);
    i_host.cmd(v);
    i_host.poll(want, d);
    check(d, stat(want));
  endtask : go
  task automatic print_verdict();
    if (err_count == 0 && samples_checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : print_verdict
  // ********
  // Sequence
  // ********
  initial
  begin
    r = 8'($urandom(32'h020C));
    repeat (6) @(negedge clk_sys_i);
    sys_rst_i = 1'b0;
    i_host.acc(1'b0, 6'h01, 8'h00, d);
    check(d, 8'h00);
    i_host.acc(1'b0, 6'h02, 8'h00, d);
    check(d, 8'h00);
    go(8'h04, 5'h00);
    do r = 8'($urandom); while (r[4:0] inside {5'h00, 5'h02, 5'h03, 5'h04, 5'h06, 5'h08, 5'h09, 5'h16, 5'h19});
    go(r, 5'h00);
    go(8'h08, 5'h08);
    go(8'h09, 5'h09);
    go({r[7:5], 5'h02}, 5'h02);
    for (int i = 0; i < 40 && n_tx == 0; i++) @(negedge clk_sys_i);
    check(8'(n_tx), 8'h01);
    i_host.acc(1'b0, 6'h02, 8'h00, d);
    check(d, 8'h02);
    ev('0, 1'b1);
    i_host.poll(5'h09, d);
    check(d, stat(5'h09));
    go(8'h03, 5'h08);
    go(8'h16, 5'h16);
    ev('{rx_start: 1'b1, default: 1'b0}, 1'b0);
    check(stat(code), stat(5'h11));
    ev('{rx_start: 1'b0, default: 1'b1}, 1'b0);
    repeat (3) @(negedge clk_sys_i);
    check(8'(n_rcv + 2 * n_ack), 8'h03);
    ev('0, 1'b1);
    i_host.poll(5'h16, d);
    check(d, stat(5'h16));
    ev('{rx_start: 1'b1, default: 1'b0}, 1'b0);
    i_host.cmd(8'h09);
    check(stat(code), stat(5'h11));
    ev('{rx_end: 1'b1, default: 1'b0}, 1'b0);
    repeat (3) @(negedge clk_sys_i);
    check(8'(n_rcv), 8'h01);
    i_host.poll(5'h09, d);
    check(d, stat(5'h09));
    go(8'h16, 5'h16);
    go(8'h03, 5'h08);
    trig = 1'b1;
    repeat (3) @(negedge clk_sys_i);
    check(stat(code), stat(5'h0F));
    i_host.acc(1'b0, 6'h01, 8'h00, d);
    check(d, 8'h00);
    trig = 1'b0;
    repeat (2) @(negedge clk_sys_i);
    trig = 1'b1;
    i_host.poll(5'h08, d);
    check(d, stat(5'h08));
    go(8'h19, 5'h19);
    i_host.cmd(8'h02);
    cc(1'b1);
    cc(1'b0);
    tx_ack_req = 1'b1;
    for (int i = 0; i < 40 && n_tx < 2; i++) @(negedge clk_sys_i);
    ev('0, 1'b1);
    pk('1, 1'b0);
    i_host.poll(5'h19, d);
    check(d, 8'hD9);
    i_host.acc(1'b0, 6'h02, 8'h00, d);
    check(d, 8'h22);
    print_verdict();
  end
endmodule : rsc_state_ctrl_tb
`default_nettype wire
